// File: hw/iepm_ctrl.v
// Functional notes
// - global enable bit gates all servicing
// - enable register 0 per-source enable bits
// - enable register 1: spi, i2c2, timer2
// - priority-low register 0 source bit layout
// - priority-high register 0 same layout
// - priority-low register 1: spi, i2c2 bits
// - priority-high register 1: spi, i2c2 bits
// - bit-addressable registers; all reset 00H
// - priority-high registers byte access only
// - sleep request bit enters idle
// - idle stops program counter, clock runs
// - enabled interrupt ends idle, clears bit
// - hardware reset ends idle and power-down
// - deep sleep request bit enters power-down
// - power-down stops clock; level externals only
// - enabled level external interrupt ends power-down
// - resume after wake pin returns high
// - four priority levels from bit pairs
// - spi and uart share one vector
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "iepm_map.vh"
module iepm_ctrl
(
	input wire clk,
	input wire srst,
	input wire ce,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire bit_wr,
	input wire [2:0] bit_sel,
	input wire bit_val,
	input wire [9:0] irq_req,
	input wire ext0_n,
	input wire ext1_n,
	input wire ext0_level,
	input wire ext1_level,
	input wire irq_ack,
	input wire irq_ret,
	output reg [7:0] rdata,
	output reg irq_valid,
	output reg [3:0] irq_src,
	output reg [1:0] irq_level,
	output reg pc_hold,
	output reg clk_stop,
	output reg addr_latch_strobe,
	output reg program_fetch_strobe
);
	// source index order: ext0,tmr0,ext1,tmr1,uart,i2c1,pca,tmr2,i2c2,spi
	localparam [3:0] SRC_SPI = 4'h9;
	localparam [3:0] SRC_UART = 4'h4;
	localparam [1:0] PM_RUN = 2'h0;
	localparam [1:0] PM_IDLE = 2'h1;
	localparam [1:0] PM_DOWN = 2'h2;
	localparam [1:0] PM_WAKE = 2'h3;

	reg [7:0] irq_enable_0_r;
	reg [7:0] irq_enable_1_r;
	reg [7:0] irq_prio_lo_0_r;
	reg [7:0] irq_prio_hi_0_r;
	reg [7:0] irq_prio_lo_1_r;
	reg [7:0] irq_prio_hi_1_r;
	reg [1:0] power_control_r;
	reg [1:0] pm_r;
	reg [1:0] pm_nxt;
	reg [`IEPM_WAKE_CNT_W-1:0] wake_cnt_r;
	reg wake_long_r;
	reg [3:0] active_r;
	reg [3:0] srv_src_nxt;
	reg [1:0] srv_lvl_nxt;
	reg srv_hit_nxt;
	reg [3:0] rank;
	integer i;
	wire [9:0] en_vec;
	wire [9:0] lo_vec;
	wire [9:0] hi_vec;
	wire [9:0] pend;
	wire ext_wake;
	wire pctl_wr;

	// map a poll rank to the source index; equal levels resolve by rank
	function [3:0] poll_src;
		input [3:0] r;
		begin
			case (r)
				4'h0: poll_src = 4'h0;
				4'h1: poll_src = 4'h5;
				4'h2: poll_src = 4'h1;
				4'h3: poll_src = 4'h2;
				4'h4: poll_src = 4'h3;
				4'h5: poll_src = 4'h4;
				4'h6: poll_src = 4'h7;
				4'h7: poll_src = 4'h6;
				4'h8: poll_src = 4'h9;
				default: poll_src = 4'h8;
			endcase
		end
	endfunction

	// merge a byte with one bit replaced, for single-bit writes
	function [7:0] set_bit;
		input [7:0] old;
		input [2:0] pos;
		input val;
		begin
			set_bit = old;
			set_bit[pos] = val;
		end
	endfunction

	// two-bit level of one source; the high bit is the more significant
	function [1:0] src_level;
		input [9:0] hv;
		input [9:0] lv;
		input [3:0] s;
		begin
			src_level = {hv[s], lv[s]};
		end
	endfunction

	assign en_vec = {irq_enable_1_r[2:0], irq_enable_0_r[6:0]};
	assign lo_vec = {irq_prio_lo_1_r[1:0], irq_prio_lo_0_r};
	assign hi_vec = {irq_prio_hi_1_r[1:0], irq_prio_hi_0_r};
	// only a held-low level external with its enable can wake power-down
	assign ext_wake = (~ext0_n & ext0_level & irq_enable_0_r[0]) |
		(~ext1_n & ext1_level & irq_enable_0_r[2]);
	// modes are entered on the write itself, so a bit still set after wake-up
	// cannot throw the part straight back into power-down before the ack
	assign pctl_wr = wr && (addr == `IEPM_OFS_POWER_CTRL);
	assign pend = (pm_r == PM_DOWN || pm_r == PM_WAKE) ? 10'h000 :
		(irq_req & en_vec & {10{irq_enable_0_r[`IEPM_BIT_GLOBAL_EN]}});

	// arbitration: highest level wins, ties by poll order, must beat active levels
	always @*
	begin
		srv_hit_nxt = 1'b0;
		srv_src_nxt = 4'h0;
		srv_lvl_nxt = 2'h0;
		rank = 4'h0;
		for (i = 0; i < `IEPM_NSRC; i = i + 1)
		begin
			rank = poll_src(i[3:0]);
			if (pend[rank] && active_r[src_level(hi_vec, lo_vec, rank)] == 1'b0 &&
				(!srv_hit_nxt || src_level(hi_vec, lo_vec, rank) > srv_lvl_nxt))
			begin
				srv_hit_nxt = 1'b1;
				srv_src_nxt = rank;
				srv_lvl_nxt = src_level(hi_vec, lo_vec, rank);
			end
		end
		// a lower level cannot preempt any higher active level
		for (i = 0; i < 4; i = i + 1)
			if (active_r[i] && i[1:0] > srv_lvl_nxt)
				srv_hit_nxt = 1'b0;
	end

	// power mode sequencing
	always @*
	begin
		pm_nxt = pm_r;
		case (pm_r)
			PM_RUN:
				if (pctl_wr && wdata[`IEPM_BIT_DEEP_SLEEP])
					pm_nxt = PM_DOWN;
				else if (pctl_wr && wdata[`IEPM_BIT_SLEEP])
					pm_nxt = PM_IDLE;
			PM_IDLE:
				if (irq_ack)
					pm_nxt = PM_RUN;
			PM_DOWN:
				if (ext_wake)
					pm_nxt = PM_WAKE;
			PM_WAKE:
				if (!ext_wake)
					pm_nxt = wake_long_r ? PM_RUN : PM_DOWN;
			default:
				pm_nxt = PM_RUN;
		endcase
	end

	// mode state; a hardware reset ends idle and power-down like a power-on
	always @(posedge clk)
	begin
		if (srst)
			pm_r <= PM_RUN;
		else if (ce)
			pm_r <= pm_nxt;
	end

	// control registers; every one comes back at its reset value
	always @(posedge clk)
	begin
		if (srst)
		begin
			irq_enable_0_r <= `IEPM_RST_VAL;
			irq_enable_1_r <= `IEPM_RST_VAL;
			irq_prio_lo_0_r <= `IEPM_RST_VAL;
			irq_prio_hi_0_r <= `IEPM_RST_VAL;
			irq_prio_lo_1_r <= `IEPM_RST_VAL;
			irq_prio_hi_1_r <= `IEPM_RST_VAL;
			power_control_r <= 2'h0;
		end
		else if (ce)
		begin
			// byte writes; reserved bits stored as zero whatever software writes
			if (wr)
			begin
				case (addr)
					`IEPM_OFS_ENABLE_0: irq_enable_0_r <= wdata;
					`IEPM_OFS_ENABLE_1: irq_enable_1_r <= wdata & `IEPM_MASK_ENABLE_1;
					`IEPM_OFS_PRIO_LO_0: irq_prio_lo_0_r <= wdata;
					`IEPM_OFS_PRIO_HI_0: irq_prio_hi_0_r <= wdata;
					`IEPM_OFS_PRIO_LO_1: irq_prio_lo_1_r <= wdata & `IEPM_MASK_PRIO_1;
					`IEPM_OFS_PRIO_HI_1: irq_prio_hi_1_r <= wdata & `IEPM_MASK_PRIO_1;
					`IEPM_OFS_POWER_CTRL: power_control_r <= wdata[1:0];
					default: ;
				endcase
			end
			// single-bit writes reach only the bit-addressable four
			else if (bit_wr)
			begin
				case (addr)
					`IEPM_OFS_ENABLE_0: irq_enable_0_r <= set_bit(irq_enable_0_r, bit_sel, bit_val);
					`IEPM_OFS_ENABLE_1:
						irq_enable_1_r <= set_bit(irq_enable_1_r, bit_sel, bit_val) & `IEPM_MASK_ENABLE_1;
					`IEPM_OFS_PRIO_LO_0: irq_prio_lo_0_r <= set_bit(irq_prio_lo_0_r, bit_sel, bit_val);
					`IEPM_OFS_PRIO_LO_1:
						irq_prio_lo_1_r <= set_bit(irq_prio_lo_1_r, bit_sel, bit_val) & `IEPM_MASK_PRIO_1;
					default: ;
				endcase
			end
			// service entry clears both request bits
			else if (irq_ack)
				power_control_r <= 2'h0;
		end
	end

	// read data stands for the one cycle after the strobe, zero otherwise
	always @(posedge clk)
	begin
		if (srst)
			rdata <= 8'h00;
		else if (ce)
		begin
			if (rd)
			begin
				case (addr)
					`IEPM_OFS_ENABLE_0: rdata <= irq_enable_0_r;
					`IEPM_OFS_ENABLE_1: rdata <= irq_enable_1_r;
					`IEPM_OFS_PRIO_LO_0: rdata <= irq_prio_lo_0_r;
					`IEPM_OFS_PRIO_HI_0: rdata <= irq_prio_hi_0_r;
					`IEPM_OFS_PRIO_LO_1: rdata <= irq_prio_lo_1_r;
					`IEPM_OFS_PRIO_HI_1: rdata <= irq_prio_hi_1_r;
					`IEPM_OFS_POWER_CTRL: rdata <= {6'h00, power_control_r};
					default: rdata <= 8'h00;
				endcase
			end
			else
				rdata <= 8'h00;
		end
	end

	// last count of the wake window, sized to the counter
	localparam [`IEPM_WAKE_CNT_W-1:0] WAKE_LAST = `IEPM_WAKE_LOW_CLKS - 1;

	// count the wake pin low time, saturating at the threshold
	// a short pulse would leave the oscillator unsettled, so the part drops back
	always @(posedge clk)
	begin
		if (srst)
		begin
			wake_cnt_r <= {`IEPM_WAKE_CNT_W{1'b0}};
			wake_long_r <= 1'b0;
		end
		else if (ce)
		begin
			if (pm_r == PM_WAKE)
			begin
				if (wake_cnt_r == WAKE_LAST)
					wake_long_r <= 1'b1;
				else
					wake_cnt_r <= wake_cnt_r + 1'b1;
			end
			else
			begin
				wake_cnt_r <= {`IEPM_WAKE_CNT_W{1'b0}};
				wake_long_r <= 1'b0;
			end
		end
	end

	// in-service levels: ack sets the level served, return clears the highest
	always @(posedge clk)
	begin
		if (srst)
			active_r <= 4'h0;
		else if (ce)
		begin
			if (irq_ack && irq_valid)
				active_r[irq_level] <= 1'b1;
			else if (irq_ret)
			begin
				if (active_r[3])
					active_r[3] <= 1'b0;
				else if (active_r[2])
					active_r[2] <= 1'b0;
				else if (active_r[1])
					active_r[1] <= 1'b0;
				else
					active_r[0] <= 1'b0;
			end
		end
	end

	// request to the core and mode outputs, all straight from flip-flops
	always @(posedge clk)
	begin
		if (srst)
		begin
			irq_valid <= 1'b0;
			irq_src <= 4'h0;
			irq_level <= 2'h0;
			pc_hold <= 1'b0;
			clk_stop <= 1'b0;
			addr_latch_strobe <= 1'b1;
			program_fetch_strobe <= 1'b1;
		end
		else if (ce)
		begin
			// drop the request in the cycle after the ack so one event gives one entry
			irq_valid <= srv_hit_nxt & ~irq_ack;
			// spi reports through the uart vector
			irq_src <= (srv_src_nxt == SRC_SPI) ? SRC_UART : srv_src_nxt;
			irq_level <= srv_lvl_nxt;
			// idle holds pc with clock running; power-down stops the clock
			pc_hold <= (pm_nxt != PM_RUN);
			clk_stop <= (pm_nxt == PM_DOWN || pm_nxt == PM_WAKE);
			addr_latch_strobe <= (pm_nxt == PM_RUN || pm_nxt == PM_IDLE);
			program_fetch_strobe <= (pm_nxt == PM_RUN || pm_nxt == PM_IDLE);
		end
	end
endmodule // iepm_ctrl

// File: hw/iepm_map.vh
`ifndef IEPM_MAP_VH
`define IEPM_MAP_VH
// register offsets
`define IEPM_OFS_PRIO_LO_1 8'h91
`define IEPM_OFS_PRIO_HI_1 8'h92
`define IEPM_OFS_ENABLE_0 8'hA8
`define IEPM_OFS_PRIO_HI_0 8'hB7
`define IEPM_OFS_PRIO_LO_0 8'hB8
`define IEPM_OFS_ENABLE_1 8'hE8
`define IEPM_OFS_POWER_CTRL 8'h87
// reset value shared by all control registers
`define IEPM_RST_VAL 8'h00
// field positions
`define IEPM_BIT_GLOBAL_EN 7
`define IEPM_BIT_SLEEP 0
`define IEPM_BIT_DEEP_SLEEP 1
// writable masks of the second-bank registers
`define IEPM_MASK_ENABLE_1 8'h07
`define IEPM_MASK_PRIO_1 8'h03
// wake-up pin low time in clocks
`define IEPM_WAKE_LOW_CLKS 1024
`define IEPM_WAKE_CNT_W 11
// number of sources
`define IEPM_NSRC 10
`endif

// File: verif/iepm_assertions.sv
`timescale 1ns/1ps
module iepm_assertions
(
	input wire clk,
	input wire srst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire irq_ack,
	input wire [7:0] rdata,
	input wire irq_valid,
	input wire pc_hold,
	input wire clk_stop,
	input wire addr_latch_strobe,
	input wire program_fetch_strobe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// a write of one mode byte to power control
	sequence s_pc(d); wr && addr == 8'h87 && wdata == d; endsequence
	property p_rst; $fell(srst) |-> !pc_hold && !clk_stop && rdata == 8'h00; endproperty
	property p_idle; s_pc(8'h01) |-> ##[1:3] pc_hold && !clk_stop; endproperty
	property p_pd; s_pc(8'h02) |-> ##[1:3] clk_stop; endproperty
	property p_istb; pc_hold && !clk_stop |-> addr_latch_strobe && program_fetch_strobe; endproperty
	property p_pstb; clk_stop |-> !addr_latch_strobe && !program_fetch_strobe; endproperty
	property p_rdz; !$past(rd) |-> rdata == 8'h00; endproperty
	property p_ack; irq_ack |=> !irq_valid; endproperty
	property p_iout; pc_hold && !clk_stop && irq_ack |-> ##[1:2] !pc_hold; endproperty
	property p_mask; clk_stop && $past(clk_stop) |-> !irq_valid; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_idle: assert property (p_idle) else $error("no idle");
	a_pd: assert property (p_pd) else $error("no power-down");
	a_istb: assert property (p_istb) else $error("strobes low in idle");
	a_pstb: assert property (p_pstb) else $error("strobes high in power-down");
	a_rdz: assert property (p_rdz) else $error("stray read data");
	a_ack: assert property (p_ack) else $error("request held after ack");
	a_iout: assert property (p_iout) else $error("idle not left");
	a_mask: assert property (p_mask) else $error("request in power-down");
endmodule // iepm_assertions
bind iepm_ctrl iepm_assertions i_iepm_assertions (.clk, .srst, .addr, .wdata, .wr, .rd, .irq_ack, .rdata,
	.irq_valid, .pc_hold, .clk_stop, .addr_latch_strobe, .program_fetch_strobe);

// File: verif/iepm_core_model.sv
`timescale 1ns/1ps
module iepm_core_model
(
	input wire clk,
	input wire srst,
	input wire irq_valid,
	output reg irq_ack,
	output reg irq_ret
);
	reg [2:0] cnt_r;
	// one routine at a time: nesting is not modelled, so preemption is untested here
	always @(posedge clk)
	begin
		irq_ack <= 1'b0;
		irq_ret <= 1'b0;
		if (srst)
			cnt_r <= 3'h0;
		else if (cnt_r == 3'h0 && irq_valid)
		begin
			irq_ack <= 1'b1;
			cnt_r <= 3'h4;
		end
		else if (cnt_r != 3'h0)
		begin
			cnt_r <= cnt_r - 3'h1;
			irq_ret <= cnt_r == 3'h1;
		end
	end
endmodule // iepm_core_model

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	reg clk, srst, ce, wr, rd, bit_wr, bit_val, ext0_n, ext0_level;
	reg [7:0] addr, wdata;
	reg [2:0] bit_sel;
	reg [9:0] irq_req;
	wire irq_ack, irq_ret, irq_valid, pc_hold, clk_stop, als, pfs;
	wire [7:0] rdata;
	wire [3:0] irq_src;
	wire [1:0] irq_level;
	wire [7:0] st = {4'h0, pc_hold, clk_stop, als, pfs};
	int err_count, n_checks, i, n_ack, k;
	reg [7:0] ofs [6] = '{8'h91, 8'h92, 8'hA8, 8'hB7, 8'hB8, 8'hE8};
	reg [7:0] msk [6] = '{8'h03, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h07};
	iepm_ctrl i_iepm_ctrl (.clk, .srst, .ce, .addr, .wdata, .wr, .rd, .bit_wr, .bit_sel, .bit_val, .irq_req,
		.ext0_n, .ext1_n(1'b1), .ext0_level, .ext1_level(1'b0), .irq_ack, .irq_ret, .rdata, .irq_valid,
		.irq_src, .irq_level, .pc_hold, .clk_stop, .addr_latch_strobe(als), .program_fetch_strobe(pfs));
	iepm_core_model i_iepm_core_model (.clk, .srst, .irq_valid, .irq_ack, .irq_ret);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) if (irq_ack === 1'b1) n_ack <= n_ack + 1;
	task chk(input [7:0] got, input [7:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wb(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rb(input [7:0] a, input [7:0] e);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	end
	endtask
	task bw(input [7:0] a, input [2:0] s);
	begin
		@(posedge clk);
		addr <= a;
		bit_sel <= s;
		bit_val <= 1'b1;
		bit_wr <= 1'b1;
		@(posedge clk);
		bit_wr <= 1'b0;
	end
	endtask
	// wait for the core to enter a routine, check what it was told, then drop that request
	task take(input [3:0] s, input [1:0] l, input [9:0] clr);
	begin
		for (k = 0; k < 2000; k++)
		begin
			@(posedge clk);
			#1;
			if (irq_ack === 1'b1)
				break;
		end
		chk({4'h0, irq_src}, {4'h0, s});
		chk({6'h0, irq_level}, {6'h0, l});
		@(posedge clk);
		irq_req <= irq_req & ~clr;
	end
	endtask
	task close_out;
	begin
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	initial
	begin
		#1000000 err_count++;
		close_out;
	end
	initial
	begin
		{srst, ce, ext0_n, ext0_level, wr, rd, bit_wr, bit_val, bit_sel, addr, wdata, irq_req} = 37'h7 << 34;
		{err_count, n_checks, n_ack} = 0;
		wt(3);
		srst <= 1'b0;
		for (i = 0; i < 6; i++) rb(ofs[i], 8'h00);
		rb(8'h00, 8'h00);
		ce <= 1'b0;
		wb(8'hB8, 8'h55);
		ce <= 1'b1;
		rb(8'hB8, 8'h00);
		bw(8'hA8, 3'h3);
		rb(8'hA8, 8'h08);
		bw(8'hB7, 3'h3);
		rb(8'hB7, 8'h00);
		for (i = 0; i < 6; i++) wb(ofs[i], 8'hFF);
		for (i = 0; i < 6; i++) rb(ofs[i], msk[i]);
		// spi at level 3, timer 0 at level 2 (high bit only), timer 1 at level 1
		wb(8'hB8, 8'h08);
		wb(8'hB7, 8'h02);
		irq_req <= 10'h20A;
		take(4'h4, 2'h3, 10'h200);
		take(4'h1, 2'h2, 10'h002);
		take(4'h3, 2'h1, 10'h008);
		wb(8'hA8, 8'h7F);
		irq_req <= 10'h001;
		k = n_ack;
		wt(20);
		chk(8'(n_ack - k), 8'h00);
		irq_req <= 10'h000;
		wb(8'hA8, 8'h81);
		wb(8'h87, 8'h01);
		wt(3);
		chk(st, 8'h0B);
		irq_req <= 10'h001;
		take(4'h0, 2'h0, 10'h001);
		wt(3);
		chk(st, 8'h03);
		rb(8'h87, 8'h00);
		rb(8'hA8, 8'h81);
		ext0_level <= 1'b1;
		wb(8'h87, 8'h02);
		wt(3);
		chk(st, 8'h0C);
		ext0_n <= 1'b0;
		irq_req <= 10'h001;
		wt(100);
		ext0_n <= 1'b1;
		wt(10);
		chk(st, 8'h0C);
		ext0_n <= 1'b0;
		wt(1100);
		ext0_n <= 1'b1;
		take(4'h0, 2'h0, 10'h001);
		wt(3);
		chk(st, 8'h03);
		rb(8'h87, 8'h00);
		wb(8'h87, 8'h02);
		wt(3);
		srst <= 1'b1;
		wt(3);
		srst <= 1'b0;
		wt(1);
		#1 chk(st, 8'h03);
		rb(8'hA8, 8'h00);
		close_out;
	end
endmodule // testbench
